// ===== rtl/pnp_config_defs.vh
`ifndef PNP_CONFIG_DEFS_VH
`define PNP_CONFIG_DEFS_VH

// ****************************************
// Keys and port layout
// ****************************************
`define KEY_ENTER        8'h55
`define KEY_EXIT         8'haa
`define DATA_PORT_STEP   16'h0001

// ****************************************
// Global register indices
// ****************************************
`define IDX_CONFIG_CTRL  8'h02
`define IDX_INDEX_ADDR   8'h03
`define IDX_FUNC_SEL     8'h07
`define IDX_CHIP_ID      8'h20
`define IDX_CHIP_REV     8'h21
`define IDX_POWER_CTRL   8'h22
`define IDX_POWER_MGMT   8'h23
`define IDX_OSC_CTRL     8'h24
`define IDX_KEY_LOW      8'h26
`define IDX_KEY_HIGH     8'h27
`define IDX_CLOCK_MASK   8'h28
`define IDX_TEST_D       8'h2b
`define IDX_TEST_E       8'h2c
`define IDX_TEST_A       8'h2d
`define IDX_TEST_B       8'h2e
`define IDX_TEST_C       8'h2f
`define IDX_BANK_FIRST   8'h30
`define SOFT_RESET_BIT   0

// ****************************************
// Reset values
// ****************************************
`define RST_INDEX_ADDR   8'h03
`define RST_OSC_CTRL     8'h04
`define RST_KEY_HIGH     8'h03
`define RST_KEY_LOW_0    8'hf0
`define RST_KEY_LOW_1    8'h70
`define RST_ZERO         8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS    40
`define POR_BLOCK_NS     500000
`define POR_BLOCK_CYCLES (`POR_BLOCK_NS / `CLK_PERIOD_NS)

`endif

// ===== rtl/pnp_config_port.v
`include "pnp_config_defs.vh"

module pnp_config_port #(
    // Identity and revision values are arbitrary
    parameter [7:0]  CHIP_ID          = 8'h5a,
    parameter [7:0]  CHIP_REV         = 8'h01,
    parameter [31:0] POR_BLOCK_CYCLES = `POR_BLOCK_CYCLES
) (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        bus_hard_reset,
    input  wire        strap,
    input  wire        aen,
    input  wire [15:0] io_addr,
    input  wire        io_write_n,
    input  wire        io_read_n,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output wire        data_oe,
    output reg  [7:0]  bank_select,
    output reg  [7:0]  bank_index,
    output reg  [7:0]  bank_wdata,
    output reg         bank_write,
    output reg         bank_read,
    input  wire [7:0]  bank_rdata,
    output reg         bank_hard_reset,
    output reg         bank_soft_reset,
    output reg         config_mode,
    output reg         host_blocked
);

    // ****************************************
    // Reset release
    // ****************************************
    reg rst_meta_n;
    reg rst_n;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    localparam RUN    = 1'b0;
    localparam CONFIG = 1'b1;

    // ****************************************
    // Registers
    // ****************************************
    reg        state;
    reg [7:0]  index;
    reg [7:0]  index_address;
    reg [7:0]  power_control;
    reg [7:0]  power_management;
    reg [7:0]  oscillator_control;
    reg [7:0]  key_port_addr_low;
    reg [7:0]  key_port_addr_high;
    reg [7:0]  clock_mask;
    reg [7:0]  test_reg_a;
    reg [7:0]  test_reg_b;
    reg [7:0]  test_reg_c;
    reg [7:0]  test_reg_d;
    reg [7:0]  test_reg_e;
    reg        strap_load;
    reg [31:0] block_count;

    // ****************************************
    // Decode
    // ****************************************
    wire [15:0] key_addr  = {key_port_addr_high, key_port_addr_low};
    wire [15:0] data_addr = key_addr + `DATA_PORT_STEP;
    wire        cpu_cycle = !aen && !host_blocked;
    wire        hit_key   = cpu_cycle && (io_addr == key_addr);
    wire        hit_data  = cpu_cycle && (io_addr == data_addr) && (state == CONFIG);
    wire        wr_go;
    wire        rd_go;
    wire        key_wr    = wr_go && hit_key;
    wire        data_wr   = wr_go && hit_data;
    wire        data_rd   = rd_go && hit_data;
    wire        is_bank   = index >= `IDX_BANK_FIRST;
    wire        glob_wr   = data_wr && !is_bank;
    wire        soft_rst  = glob_wr && (index == `IDX_CONFIG_CTRL)
                            && data_in[`SOFT_RESET_BIT];

    // Index port reads back only in Configuration; in Run the key port is write-only
    assign data_oe = !io_read_n && ((hit_key && (state == CONFIG)) || hit_data);

    // ****************************************
    // Strobe edges
    // ****************************************
    // A transfer is taken once, on the first low cycle of its strobe
    strobe_fall #(
        .IDLE_LEVEL (1'b1)
    ) u_write_fall (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .strobe_n (io_write_n),
        .fall     (wr_go)
    );

    strobe_fall #(
        .IDLE_LEVEL (1'b1)
    ) u_read_fall (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .strobe_n (io_read_n),
        .fall     (rd_go)
    );

    // ****************************************
    // Power-on access block
    // ****************************************
    // Only the supply reset starts the window; a bus hard reset does not
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_count  <= 32'h0000_0000;
            host_blocked <= 1'b1;
        end else if (block_count < POR_BLOCK_CYCLES - 32'h0000_0001) begin
            block_count  <= block_count + 32'h0000_0001;
        end else begin
            host_blocked <= 1'b0;
        end
    end

    // ****************************************
    // Access state
    // ****************************************
    // A hard reset lands in Run whatever key write is in flight
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RUN;
        end else if (bus_hard_reset) begin
            state <= RUN;
        end else begin
            case (state)
                RUN: begin
                    if (key_wr && (data_in == `KEY_ENTER))
                        state <= CONFIG;
                end
                CONFIG: begin
                    if (key_wr && (data_in == `KEY_EXIT))
                        state <= RUN;
                end
                default: state <= RUN;
            endcase
        end
    end

    always @* begin
        config_mode = (state == CONFIG);
    end

    // ****************************************
    // Index port
    // ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            index <= `RST_ZERO;
        end else if (bus_hard_reset) begin
            index <= `RST_ZERO;
        end else if (key_wr && (state == CONFIG) && (data_in != `KEY_EXIT)) begin
            index <= data_in;
        end
    end

    // ****************************************
    // Strap capture
    // ****************************************
    // The strap is followed while hard reset holds, so the level at its release is kept
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_load <= 1'b1;
        end else begin
            strap_load <= bus_hard_reset;
        end
    end

    // ****************************************
    // Global registers
    // ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_address      <= `RST_INDEX_ADDR;
            bank_select        <= `RST_ZERO;
            power_control      <= `RST_ZERO;
            power_management   <= `RST_ZERO;
            oscillator_control <= `RST_OSC_CTRL;
            key_port_addr_low  <= `RST_KEY_LOW_0;
            key_port_addr_high <= `RST_KEY_HIGH;
            clock_mask         <= `RST_ZERO;
            test_reg_a         <= `RST_ZERO;
            test_reg_b         <= `RST_ZERO;
            test_reg_c         <= `RST_ZERO;
            test_reg_d         <= `RST_ZERO;
            test_reg_e         <= `RST_ZERO;
        end else if (bus_hard_reset || strap_load) begin
            // Test registers keep their contents across a bus hard reset
            index_address      <= `RST_INDEX_ADDR;
            bank_select        <= `RST_ZERO;
            power_control      <= `RST_ZERO;
            power_management   <= `RST_ZERO;
            oscillator_control <= `RST_OSC_CTRL;
            key_port_addr_low  <= strap ? `RST_KEY_LOW_1 : `RST_KEY_LOW_0;
            key_port_addr_high <= `RST_KEY_HIGH;
            clock_mask         <= `RST_ZERO;
        end else if (soft_rst) begin
            bank_select        <= `RST_ZERO;
            power_control      <= `RST_ZERO;
            clock_mask         <= `RST_ZERO;
        end else if (data_wr) begin
            case (index)
                `IDX_INDEX_ADDR: index_address      <= data_in;
                `IDX_FUNC_SEL:   bank_select        <= data_in;
                `IDX_POWER_CTRL: power_control      <= data_in;
                `IDX_POWER_MGMT: power_management   <= data_in;
                `IDX_OSC_CTRL:   oscillator_control <= data_in;
                `IDX_KEY_LOW:    key_port_addr_low  <= data_in;
                `IDX_KEY_HIGH:   key_port_addr_high <= data_in;
                `IDX_CLOCK_MASK: clock_mask         <= data_in;
                `IDX_TEST_A:     test_reg_a         <= data_in;
                `IDX_TEST_B:     test_reg_b         <= data_in;
                `IDX_TEST_C:     test_reg_c         <= data_in;
                `IDX_TEST_D:     test_reg_d         <= data_in;
                `IDX_TEST_E:     test_reg_e         <= data_in;
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Logical device bank path
    // ****************************************
    // Index and data are held after the strobe so the bank may sample them late
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_index      <= `RST_ZERO;
            bank_wdata      <= `RST_ZERO;
            bank_write      <= 1'b0;
            bank_read       <= 1'b0;
            bank_hard_reset <= 1'b1;
            bank_soft_reset <= 1'b0;
        end else begin
            bank_index      <= index;
            bank_write      <= data_wr && is_bank;
            bank_read       <= data_rd && is_bank;
            bank_hard_reset <= bus_hard_reset;
            bank_soft_reset <= soft_rst;
            if (data_wr)
                bank_wdata  <= data_in;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Registered, so a read must hold its address a cycle before data is taken
    reg [7:0] next_data_out;

    always @* begin
        next_data_out = `RST_ZERO;
        if (hit_key && (state == CONFIG)) begin
            next_data_out = index;
        end else if (is_bank) begin
            next_data_out = bank_rdata;
        end else begin
            case (index)
                `IDX_INDEX_ADDR: next_data_out = index_address;
                `IDX_FUNC_SEL:   next_data_out = bank_select;
                `IDX_CHIP_ID:    next_data_out = CHIP_ID;
                `IDX_CHIP_REV:   next_data_out = CHIP_REV;
                `IDX_POWER_CTRL: next_data_out = power_control;
                `IDX_POWER_MGMT: next_data_out = power_management;
                `IDX_OSC_CTRL:   next_data_out = oscillator_control;
                `IDX_KEY_LOW:    next_data_out = key_port_addr_low;
                `IDX_KEY_HIGH:   next_data_out = key_port_addr_high;
                `IDX_CLOCK_MASK: next_data_out = clock_mask;
                `IDX_TEST_A:     next_data_out = test_reg_a;
                `IDX_TEST_B:     next_data_out = test_reg_b;
                `IDX_TEST_C:     next_data_out = test_reg_c;
                `IDX_TEST_D:     next_data_out = test_reg_d;
                `IDX_TEST_E:     next_data_out = test_reg_e;
                default:         next_data_out = `RST_ZERO;
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `RST_ZERO;
        end else begin
            data_out <= next_data_out;
        end
    end

endmodule // pnp_config_port

// ****************************************
// Strobe falling edge
// ****************************************
module strobe_fall #(
    parameter [0:0] IDLE_LEVEL = 1'b1
) (
    input  wire clk,
    input  wire rst_n,
    input  wire strobe_n,
    output wire fall
);

    reg prev_n;

    // Resting at the idle level lets a strobe held low through reset count as an edge once reset ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_n <= IDLE_LEVEL;
        end else begin
            prev_n <= strobe_n;
        end
    end

    assign fall = !strobe_n && prev_n;

endmodule // strobe_fall

// ===== bench/pnp_config_port_asserts.sv
module pnp_config_port_chk #(
    parameter [15:0] KEY = 16'h03f0
) (
    input wire        sys_clk,
    input wire        resetn,
    input wire        bus_hard_reset,
    input wire        aen,
    input wire [15:0] io_addr,
    input wire        io_write_n,
    input wire        io_read_n,
    input wire [7:0]  data_in,
    input wire        data_oe,
    input wire [7:0]  bank_select,
    input wire [7:0]  bank_index,
    input wire [7:0]  bank_wdata,
    input wire        bank_write,
    input wire        bank_read,
    input wire        bank_hard_reset,
    input wire        bank_soft_reset,
    input wire        config_mode,
    input wire        host_blocked
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Write and read edge detect
    // ****************************************
    reg  wr_prev;
    reg  rd_prev;
    wire wr_ok  = !io_write_n && wr_prev && !aen && !host_blocked;
    wire at_key = io_addr == KEY;
    wire at_dat = io_addr == KEY + 16'h0001;
    wire dat_wr = wr_ok && at_dat && config_mode;
    wire dat_rd = !io_read_n && rd_prev && !aen && !host_blocked && at_dat && config_mode;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
        end else begin
            wr_prev <= io_write_n;
            rd_prev <= io_read_n;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_key(v);
        wr_ok && at_key && data_in == v;
    endsequence
    sequence s_pulse;
        bank_soft_reset ##1 !bank_soft_reset;
    endsequence
    // ****************************************
    // Properties
    // ****************************************
    AST_ENTER: assert property (s_key(8'h55) ##0 !config_mode |=> config_mode)
        else $error("entry key ignored");
    AST_EXIT: assert property (s_key(8'haa) ##0 config_mode |=> !config_mode)
        else $error("exit key ignored");
    AST_RUN_HOLD: assert property (wr_ok && at_key && data_in != 8'h55 && !config_mode
        |=> !config_mode) else $error("wrong key changed state");
    AST_BLOCKED: assert property (host_blocked |-> !config_mode)
        else $error("access taken while blocked");
    AST_BLOCK_KEY: assert property (host_blocked && !io_write_n && wr_prev && !aen && at_key
        && !config_mode |=> !config_mode) else $error("entry key taken while blocked");
    AST_RUN_QUIET: assert property (!config_mode |-> !data_oe)
        else $error("data driven in run state");
    AST_DATA_OE: assert property (config_mode && !io_read_n && !aen && at_dat |-> data_oe)
        else $error("data port read not driven");
    AST_SELECT: assert property (dat_wr && bank_index == 8'h07
        |=> bank_select == $past(data_in)) else $error("bank select not latched");
    AST_BANK_WR: assert property (dat_wr && bank_index >= 8'h30
        |=> bank_write && bank_wdata == $past(data_in)) else $error("bank write missing");
    AST_BANK_RD: assert property (dat_rd && bank_index >= 8'h30 |=> bank_read)
        else $error("bank read missing");
    AST_GLOBAL: assert property (dat_wr && bank_index < 8'h30 |=> !bank_write)
        else $error("global write reached bank");
    AST_SOFT: assert property (dat_wr && bank_index == 8'h02 && data_in[0]
        |=> bank_select == 8'h00 ##0 s_pulse) else $error("soft reset missing");
    AST_HARD: assert property (bus_hard_reset |=> !config_mode && !bank_write && bank_hard_reset)
        else $error("hard reset left configuration");
endmodule // pnp_config_port_chk

bind pnp_config_port pnp_config_port_chk u_chk (.sys_clk, .resetn, .bus_hard_reset, .aen,
    .io_addr, .io_write_n, .io_read_n, .data_in, .data_oe, .bank_select, .bank_index,
    .bank_wdata, .bank_write, .bank_read, .bank_hard_reset, .bank_soft_reset, .config_mode,
    .host_blocked);

// ===== bench/host_bus.sv
module host_bus (
    input  wire         sys_clk,
    input  wire  [7:0]  data_out,
    output logic        aen = 1'b1,
    output logic [15:0] io_addr = 16'h0000,
    output logic        io_write_n = 1'b1,
    output logic        io_read_n = 1'b1,
    output logic [7:0]  data_in = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released lines show the inverse so a stale value is never mistaken for a live one
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d, input logic q);
        aen <= q;
        io_addr <= a;
        data_in <= d;
        io_write_n <= 1'b0;
        @(posedge sys_clk);
        io_write_n <= 1'b1;
        aen <= 1'b1;
        io_addr <= ~a;
        data_in <= ~d;
        @(posedge sys_clk);
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        aen <= 1'b0;
        io_addr <= a;
        io_read_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        d = data_out;
        io_read_n <= 1'b1;
        aen <= 1'b1;
        io_addr <= ~a;
        @(posedge sys_clk);
    endtask
endmodule // host_bus

// ===== bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [15:0] KEY = 16'h03f0;
    localparam [7:0]  ID  = 8'h5a;  // Arbitrary identity value
    localparam [7:0]  REV = 8'h01;  // Arbitrary revision value
    logic sys_clk = 0, resetn = 0, bus_hard_reset = 0, strap = 0;
    wire aen, io_write_n, io_read_n, data_oe, bank_write, bank_read;
    wire bank_hard_reset, bank_soft_reset, config_mode, host_blocked;
    wire [15:0] io_addr;
    wire [7:0] data_in, data_out, bank_select, bank_index, bank_wdata;
    logic [7:0] bmem [0:2047];
    wire [7:0] bank_rdata = bmem[{bank_select[2:0], bank_index}];
    integer miscompares = 0, total_checks = 0, seed = 32'h3a29, sel = 0, k, ld;
    logic [7:0] gref [0:47];
    logic [7:0] bref [int];
    logic [7:0] g;
    always #20 sys_clk = ~sys_clk;
    // Far side bank registers answer at once
    always @(posedge sys_clk) if (bank_write) bmem[{bank_select[2:0], bank_index}] <= bank_wdata;
    pnp_config_port #(.CHIP_ID(ID), .CHIP_REV(REV), .POR_BLOCK_CYCLES(8)) u_pnp_config_port (
        .sys_clk, .resetn, .bus_hard_reset, .strap, .aen, .io_addr, .io_write_n, .io_read_n,
        .data_in, .data_out, .data_oe, .bank_select, .bank_index, .bank_wdata, .bank_write,
        .bank_read, .bank_rdata, .bank_hard_reset, .bank_soft_reset, .config_mode, .host_blocked);
    host_bus u_host_bus (.sys_clk, .data_out, .aen, .io_addr, .io_write_n, .io_read_n, .data_in);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
        total_checks++;
        if (v !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, v);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_host_bus.io_wr(a, d, 1'b0);
    endtask
    task automatic put(input logic [7:0] i, input logic [7:0] d);
        wr(KEY, i);
        wr(KEY + 16'h0001, d);
        if (i >= 8'h30) bref[sel * 256 + i] = d;
        else if (i == 8'h07) sel = d;
        else if (i inside {8'h22, 8'h23, 8'h24, 8'h28, [8'h2b:8'h2f]}) gref[i] = d;
        if (i == 8'h02 && d[0]) begin
            sel = 0;
            gref[8'h22] = 8'h00;
            gref[8'h28] = 8'h00;
        end
    endtask
    task automatic look(input logic [7:0] i);
        logic [7:0] e;
        wr(KEY, i);
        u_host_bus.io_rd(KEY + 16'h0001, g);
        if (i >= 8'h30) e = bref.exists(sel * 256 + i) ? bref[sel * 256 + i] : 8'h00;
        else e = (i == 8'h07) ? sel[7:0] : gref[i];
        chk("data", e, g);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        foreach (gref[i]) gref[i] = 8'h00;
        foreach (bmem[i]) bmem[i] = 8'h00;
        {gref[8'h20], gref[8'h21], gref[8'h24], gref[8'h26], gref[8'h27]} = {ID, REV, 24'h04f003};
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(KEY, 8'h55);
        chk("config_mode", 8'h00, {7'h0, config_mode});
        chk("host_blocked", 8'h01, {7'h0, host_blocked});
        for (k = 0; k < 100 && host_blocked !== 1'b0; k++) @(posedge sys_clk);
        chk("host_blocked", 8'h00, {7'h0, host_blocked});
        wr(KEY, 8'h54);
        u_host_bus.io_wr(KEY, 8'h55, 1'b1);
        chk("config_mode", 8'h00, {7'h0, config_mode});
        wr(KEY, 8'h07);
        wr(KEY + 16'h0001, 8'h05);
        wr(KEY, 8'h55);
        chk("config_mode", 8'h01, {7'h0, config_mode});
        look(8'h07);
        look(8'h02);
        u_host_bus.io_rd(KEY, g);
        chk("index", 8'h02, g);
        for (k = 8'h20; k < 8'h30; k++) look(k[7:0]);
        foreach (gref[i]) if (i inside {8'h22, 8'h23, 8'h24, 8'h28, [8'h2b:8'h2f]})
            put(i[7:0], 8'($random(seed)));
        for (k = 8'h20; k < 8'h30; k++) look(k[7:0]);
        for (ld = 0; ld < 3; ld++) begin
            put(8'h07, ld[7:0] + 8'h02);
            chk("bank_select", sel[7:0], bank_select);
            put(8'h30, 8'($random(seed)));
            put(8'hf0, 8'($random(seed)));
        end
        for (ld = 0; ld < 3; ld++) begin
            put(8'h07, ld[7:0] + 8'h02);
            look(8'h30);
            look(8'hf0);
            look(8'h20);
        end
        put(8'h02, 8'h00);
        look(8'h07);
        put(8'h02, 8'h01);
        look(8'h07);
        look(8'h22);
        look(8'h23);
        look(8'h28);
        look(8'h2b);
        wr(KEY, 8'haa);
        chk("config_mode", 8'h00, {7'h0, config_mode});
        wr(KEY, 8'h55);
        chk("config_mode", 8'h01, {7'h0, config_mode});
        put(8'h07, 8'h03);
        bus_hard_reset <= 1'b1;
        @(posedge sys_clk);
        bus_hard_reset <= 1'b0;
        @(posedge sys_clk);
        chk("config_mode", 8'h00, {7'h0, config_mode});
        chk("bank_hard_reset", 8'h01, {7'h0, bank_hard_reset});
        sel = 0;
        {gref[8'h22], gref[8'h23], gref[8'h24], gref[8'h28]} = 32'h00000400;
        wr(KEY, 8'h55);
        look(8'h07);
        for (k = 8'h20; k < 8'h30; k++) look(k[7:0]);
        // Second supply reset in mid-run: window restarts, test registers clear
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("bank_hard_reset", 8'h01, {7'h0, bank_hard_reset});
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(KEY, 8'h55);
        chk("config_mode", 8'h00, {7'h0, config_mode});
        for (k = 0; k < 100 && host_blocked !== 1'b0; k++) @(posedge sys_clk);
        chk("host_blocked", 8'h00, {7'h0, host_blocked});
        foreach (gref[i]) if (i >= 8'h2b) gref[i] = 8'h00;
        wr(KEY, 8'h55);
        for (k = 8'h20; k < 8'h30; k++) look(k[7:0]);
        // Strap high at a hard reset moves the key port
        strap <= 1'b1;
        bus_hard_reset <= 1'b1;
        @(posedge sys_clk);
        bus_hard_reset <= 1'b0;
        @(posedge sys_clk);
        wr(16'h0370, 8'h55);
        wr(16'h0370, 8'h26);
        u_host_bus.io_rd(16'h0371, g);
        chk("key_port_addr_low", 8'h70, g);
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        results();
    end
endmodule // tb_top
